/* hw/modem_status_top.sv */
// Behaviour
// - Status bit 4 shows the inverted clear-to-send pin of its port.
// - Status bit 0 sets when clear-to-send pin rises since last status read.
// - Clear-to-send level never gates or stalls the transmitter.
// - Status bit 5 shows the inverted data-set-ready pin of its port.
// - Status bit 1 sets when data-set-ready pin rises since last status read.
// - Status bit 7 shows the inverted carrier-detect pin of its port.
// - Status bit 3 sets when carrier-detect pin rises since last status read.
// - Status bit 6 shows the inverted ring-indicate pin of its port.
// - Status bit 2 sets when ring-indicate pin rises since last status read.
// - With enable bit 3 set, any handshake pin change raises port interrupt.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "msr_cfg.svh"

module modem_status_top
    import msr_pkg::*;
(
    input  logic        ref_clk,
    input  logic        rst_b,
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    input  logic [1:0]  clear_to_send_in_n,
    input  logic [1:0]  data_set_ready_in_n,
    input  logic [1:0]  ring_indicate_in_n,
    input  logic [1:0]  carrier_detect_in_n,
    output logic [1:0]  port_intr,
    output logic        irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Word-aligned address to register select
    function automatic reg_sel_e decode_addr(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'b00};
        case (word)
            `MS_OFF_STATUS0:  decode_addr = SEL_STATUS0;
            `MS_OFF_IEN0:     decode_addr = SEL_IEN0;
            `MS_OFF_STATUS1:  decode_addr = SEL_STATUS1;
            `MS_OFF_IEN1:     decode_addr = SEL_IEN1;
            `MS_OFF_INT_STAT: decode_addr = SEL_INT_ST;
            `MS_OFF_INT_MASK: decode_addr = SEL_INT_MK;
            default:          decode_addr = SEL_NONE;
        endcase
    endfunction : decode_addr

    // Status register image from one port
    function automatic logic [7:0] status_image(input logic [3:0] level, input logic [3:0] delta);
        status_image = {level, delta};
    endfunction : status_image

    // ----------------------------------------
    // Port sense instances
    // ----------------------------------------
    msr_link_if link0 ();
    msr_link_if link1 ();

    // Pins grouped per port: dcd, ri, dsr, cts
    msr_port_sense sense0 (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pins_n  ({carrier_detect_in_n[0], ring_indicate_in_n[0],
                   data_set_ready_in_n[0], clear_to_send_in_n[0]}),
        .link    (link0)
    );

    msr_port_sense sense1 (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pins_n  ({carrier_detect_in_n[1], ring_indicate_in_n[1],
                   data_set_ready_in_n[1], clear_to_send_in_n[1]}),
        .link    (link1)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    ctrl_state_s r_reg;
    ctrl_state_s r_next;

    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        do_write;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_strb;
    reg_sel_e    wr_sel;
    reg_sel_e    rd_sel;
    logic [1:0]  int_set;
    logic [1:0]  int_clr;

    // ----------------------------------------
    // Handshake outputs
    // ----------------------------------------
    assign s_axi_awready = (r_reg.wr_state == WR_IDLE) && !r_reg.aw_got;
    assign s_axi_wready  = (r_reg.wr_state == WR_IDLE) && !r_reg.w_got;
    assign s_axi_bvalid  = (r_reg.wr_state == WR_RESP);
    assign s_axi_arready = (r_reg.rd_state == RD_IDLE);
    assign s_axi_rvalid  = (r_reg.rd_state == RD_DATA);

    // Data outputs from flops, upper bits zero
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_rresp = r_reg.rresp;
    assign s_axi_rdata = {24'h000000, r_reg.rdata};

    // Handshakes this cycle
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs  = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    // Write fires once address and data are both accepted, this cycle or held
    assign do_write = (aw_hs || r_reg.aw_got) && (w_hs || r_reg.w_got);
    assign wr_addr  = aw_hs ? s_axi_awaddr : r_reg.awaddr;
    assign wr_data  = w_hs ? s_axi_wdata[7:0] : r_reg.wdata;
    assign wr_strb  = w_hs ? s_axi_wstrb[0] : r_reg.wstrb0;
    assign wr_sel   = decode_addr(wr_addr);
    assign rd_sel   = decode_addr(s_axi_araddr);

    // ----------------------------------------
    // Change flag clearing on status read
    // ----------------------------------------
    assign link0.clear = ar_hs && (rd_sel == SEL_STATUS0);
    assign link1.clear = ar_hs && (rd_sel == SEL_STATUS1);

    // ----------------------------------------
    // Interrupt events
    // ----------------------------------------
    // Handshake change with modem interrupt enabled
    assign int_set = {link1.change & r_reg.ien1[`MS_IEN_MODEM_BIT],
                      link0.change & r_reg.ien0[`MS_IEN_MODEM_BIT]};
    assign int_clr = {2{ar_hs && (rd_sel == SEL_INT_ST)}};

    // Per-port interrupt, held until the status read
    assign port_intr = {link1.pending & r_reg.ien1[`MS_IEN_MODEM_BIT],
                        link0.pending & r_reg.ien0[`MS_IEN_MODEM_BIT]};

    // Summary line, unmasked sticky bits
    assign irq = |(r_reg.int_st & r_reg.int_mk);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        r_next = r_reg;

        // Sticky status, set wins over read clear
        r_next.int_st = (r_reg.int_st & ~int_clr) | int_set;

        // Write channel
        unique case (r_reg.wr_state)
            WR_IDLE:
            begin
                if (do_write)
                begin
                    r_next.aw_got   = 1'b0;
                    r_next.w_got    = 1'b0;
                    r_next.wr_state = WR_RESP;
                    r_next.bresp    = `MS_RESP_OKAY;
                    // Status and sticky registers are read only
                    unique case (wr_sel)
                        SEL_IEN0:
                        begin
                            if (wr_strb)
                                r_next.ien0 = wr_data;
                        end
                        SEL_IEN1:
                        begin
                            if (wr_strb)
                                r_next.ien1 = wr_data;
                        end
                        SEL_INT_MK:
                        begin
                            if (wr_strb)
                                r_next.int_mk = wr_data[1:0];
                        end
                        SEL_STATUS0, SEL_STATUS1, SEL_INT_ST:
                        begin
                            r_next.bresp = `MS_RESP_OKAY;
                        end
                        SEL_NONE:
                        begin
                            r_next.bresp = `MS_RESP_SLVERR;
                        end
                        default:
                        begin
                            r_next.bresp = `MS_RESP_SLVERR;
                        end
                    endcase
                end
                else
                begin
                    // Hold whichever half came first
                    if (aw_hs)
                    begin
                        r_next.aw_got = 1'b1;
                        r_next.awaddr = s_axi_awaddr;
                    end
                    if (w_hs)
                    begin
                        r_next.w_got  = 1'b1;
                        r_next.wdata  = s_axi_wdata[7:0];
                        r_next.wstrb0 = s_axi_wstrb[0];
                    end
                end
            end
            WR_RESP:
            begin
                if (s_axi_bready)
                    r_next.wr_state = WR_IDLE;
            end
        endcase

        // Read channel
        unique case (r_reg.rd_state)
            RD_IDLE:
            begin
                if (ar_hs)
                begin
                    r_next.rd_state = RD_DATA;
                    r_next.rresp    = `MS_RESP_OKAY;
                    r_next.rdata    = 8'h00;
                    unique case (rd_sel)
                        // CTS reaches only the status image and the port change interrupt
                        SEL_STATUS0: r_next.rdata = status_image(link0.level, link0.delta);
                        SEL_STATUS1: r_next.rdata = status_image(link1.level, link1.delta);
                        SEL_IEN0:    r_next.rdata = r_reg.ien0;
                        SEL_IEN1:    r_next.rdata = r_reg.ien1;
                        SEL_INT_ST:  r_next.rdata = {6'h00, r_reg.int_st};
                        SEL_INT_MK:  r_next.rdata = {6'h00, r_reg.int_mk};
                        SEL_NONE:    r_next.rresp = `MS_RESP_SLVERR;
                        default:     r_next.rresp = `MS_RESP_SLVERR;
                    endcase
                end
            end
            RD_DATA:
            begin
                if (s_axi_rready)
                    r_next.rd_state = RD_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_reg          <= '0;
            r_reg.wr_state <= WR_IDLE;
            r_reg.rd_state <= RD_IDLE;
            r_reg.ien0     <= `MS_IEN_RST;
            r_reg.ien1     <= `MS_IEN_RST;
            r_reg.int_st   <= `MS_INT_RST;
            r_reg.int_mk   <= `MS_INT_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

endmodule : modem_status_top

/* hw/msr_cfg.svh */
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MS_OFF_STATUS0   8'h00
`define MS_OFF_IEN0      8'h04
`define MS_OFF_STATUS1   8'h10
`define MS_OFF_IEN1      8'h14
`define MS_OFF_INT_STAT  8'h20
`define MS_OFF_INT_MASK  8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MS_DELTA_LSB     0
`define MS_LEVEL_LSB     4
`define MS_IEN_MODEM_BIT 3

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define MS_IEN_RST       8'h00
`define MS_INT_RST       2'h0
`define MS_PIN_IDLE      4'hf
`define MS_RESP_OKAY     2'h0
`define MS_RESP_SLVERR   2'h2

`endif

/* hw/msr_link_if.sv */
`timescale 1ns/1ps

// Status of one port between sense logic and register block
interface msr_link_if;
    logic [3:0] level;
    logic [3:0] delta;
    logic       pending;
    logic       change;
    logic       clear;

    modport sense (output level, output delta, output pending, output change, input clear);
    modport ctrl  (input level, input delta, input pending, input change, output clear);
endinterface : msr_link_if

/* hw/msr_pkg.sv */
package msr_pkg;

    // Register select from the address decoder
    typedef enum logic [2:0] {
        SEL_NONE    = 3'h0,
        SEL_STATUS0 = 3'h1,
        SEL_IEN0    = 3'h2,
        SEL_STATUS1 = 3'h3,
        SEL_IEN1    = 3'h4,
        SEL_INT_ST  = 3'h5,
        SEL_INT_MK  = 3'h6
    } reg_sel_e;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } rd_state_e;

    // Per-port sense state
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] filt;
        logic [3:0] delta;
        logic       pending;
        logic       evt;
    } sense_state_s;

    // Bus and register state
    typedef struct packed {
        wr_state_e  wr_state;
        rd_state_e  rd_state;
        logic       aw_got;
        logic       w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic       wstrb0;
        logic [1:0] bresp;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ien0;
        logic [7:0] ien1;
        logic [1:0] int_st;
        logic [1:0] int_mk;
    } ctrl_state_s;

endpackage : msr_pkg

/* hw/msr_port_sense.sv */
`timescale 1ns/1ps
`include "msr_cfg.svh"

module msr_port_sense
    import msr_pkg::*;
(
    input  logic       ref_clk,
    input  logic       rst_b,
    input  logic [3:0] pins_n,
    msr_link_if.sense  link
);

    sense_state_s r_reg;
    sense_state_s r_next;
    logic [3:0]   agree;

    // ----------------------------------------
    // Synchroniser, filter and change flags
    // ----------------------------------------
    // Pin order: 0 cts, 1 dsr, 2 ri, 3 dcd
    always_comb
    begin
        r_next    = r_reg;
        r_next.s1 = pins_n;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        agree     = ~(r_reg.s2 ^ r_reg.s3);
        // Level accepted once stages two and three agree
        r_next.filt = (r_reg.filt & ~agree) | (r_reg.s3 & agree);
        // Pin low to high sets flag; set beats read clear
        r_next.delta = (r_reg.delta & ~{4{link.clear}})
                     | (agree & r_reg.s3 & ~r_reg.filt);
        // Any edge, either direction
        r_next.evt     = |(agree & (r_reg.s3 ^ r_reg.filt));
        r_next.pending = (r_reg.pending & ~link.clear) | r_next.evt;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_reg         <= '0;
            r_reg.s1      <= `MS_PIN_IDLE;
            r_reg.s2      <= `MS_PIN_IDLE;
            r_reg.s3      <= `MS_PIN_IDLE;
            r_reg.filt    <= `MS_PIN_IDLE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.level   = ~r_reg.filt;
    assign link.delta   = r_reg.delta;
    assign link.pending = r_reg.pending;
    assign link.change  = r_reg.evt;

endmodule : msr_port_sense

/* tb/modem_model.sv */
`timescale 1ns/1ps

module modem_model (
    input  logic       ref_clk,
    input  logic [7:0] want_n,
    input  logic [3:0] lag,
    output logic [1:0] clear_to_send_in_n,
    output logic [1:0] data_set_ready_in_n,
    output logic [1:0] ring_indicate_in_n,
    output logic [1:0] carrier_detect_in_n
);
    logic [7:0] line_reg = 8'hff;
    logic [3:0] wait_reg = 4'h0;

    // Lines follow the requested levels lag plus one cycles after they change
    always @(posedge ref_clk)
    begin
        if (want_n == line_reg)
            wait_reg <= 4'h0;
        else if (wait_reg >= lag)
        begin
            line_reg <= want_n;
            wait_reg <= 4'h0;
        end
        else
            wait_reg <= wait_reg + 4'h1;
    end

    // Two bits per line kind, port 0 low
    assign {carrier_detect_in_n, ring_indicate_in_n, data_set_ready_in_n, clear_to_send_in_n} = line_reg;
endmodule : modem_model

/* tb/modem_status_top_asserts.sv */
`timescale 1ns/1ps

module modem_status_top_asserts (
    input logic        ref_clk,
    input logic        rst_b,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic [1:0]  clear_to_send_in_n,
    input logic [1:0]  data_set_ready_in_n,
    input logic [1:0]  ring_indicate_in_n,
    input logic [1:0]  carrier_detect_in_n,
    input logic [1:0]  port_intr
);
    logic [3:0] pin0;
    logic [3:0] pin1;
    logic [3:0] calm0;
    logic [3:0] calm1;
    logic       rd0;
    logic       rd1;

    // Pins and status reads of each port
    assign pin0 = {carrier_detect_in_n[0], ring_indicate_in_n[0], data_set_ready_in_n[0], clear_to_send_in_n[0]};
    assign pin1 = {carrier_detect_in_n[1], ring_indicate_in_n[1], data_set_ready_in_n[1], clear_to_send_in_n[1]};
    assign rd0 = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00;
    assign rd1 = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10;

    // Cycles since reset or last pin change, saturating
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            calm0 <= 4'h0;
            calm1 <= 4'h0;
        end
        else
        begin
            calm0 <= !$stable(pin0) ? 4'h0 : calm0 + {3'h0, calm0 != 4'hf};
            calm1 <= !$stable(pin1) ? 4'h0 : calm1 + {3'h0, calm1 != 4'hf};
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_cts_level: assert property (calm0 == 4'hf && rd0 |=> s_axi_rvalid && s_axi_rdata[4] == !$past(pin0[0]))
        else $error("cts level wrong in port 0 status");
    a_dsr_level: assert property (calm0 == 4'hf && rd0 |=> s_axi_rdata[5] == !$past(pin0[1]))
        else $error("dsr level wrong in port 0 status");
    a_ri_level: assert property (calm1 == 4'hf && rd1 |=> s_axi_rvalid && s_axi_rdata[6] == !$past(pin1[2]))
        else $error("ri level wrong in port 1 status");
    a_dcd_level: assert property (calm1 == 4'hf && rd1 |=> s_axi_rdata[7] == !$past(pin1[3]))
        else $error("dcd level wrong in port 1 status");
    a_read_clears0: assert property (calm0 == 4'hf && rd0 |=> !port_intr[0])
        else $error("port 0 interrupt kept after status read");
    a_read_clears1: assert property (calm1 == 4'hf && rd1 |=> !port_intr[1])
        else $error("port 1 interrupt kept after status read");
    a_intr_cause0: assert property ($rose(port_intr[0]) |-> calm0 != 4'hf)
        else $error("port 0 interrupt without pin change");
    a_intr_cause1: assert property ($rose(port_intr[1]) |-> calm1 != 4'hf)
        else $error("port 1 interrupt without pin change");
endmodule : modem_status_top_asserts

bind modem_status_top modem_status_top_asserts u_asserts (
    .ref_clk, .rst_b, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .clear_to_send_in_n, .data_set_ready_in_n, .ring_indicate_in_n, .carrier_detect_in_n, .port_intr
);

/* tb/modem_status_top_tb.sv */
`timescale 1ns/1ps

module modem_status_top_tb;
    logic        ref_clk = 1'b0, rst_b = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, want_n = 8'hff;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, lag = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, port_intr;
    logic [1:0]  clear_to_send_in_n, data_set_ready_in_n, ring_indicate_in_n, carrier_detect_in_n;
    int          error_cnt = 0, comparisons = 0, cycles = 0;

    modem_status_top dut (
        .ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .clear_to_send_in_n, .data_set_ready_in_n, .ring_indicate_in_n, .carrier_detect_in_n, .port_intr, .irq
    );

    modem_model modem (
        .ref_clk, .want_n, .lag, .clear_to_send_in_n, .data_set_ready_in_n, .ring_indicate_in_n, .carrier_detect_in_n
    );

    // Clock and hang guard
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus write: address and data together, bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        logic aw, w, b;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            #1;
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge ref_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask : wr

    // Bus read, then data and response compared
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic ar, r;
        logic [31:0] d;
        logic [1:0] resp;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        while (!r)
        begin
            #1;
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge ref_clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
        chk(d, exp);
        chk({30'h0, resp}, {30'h0, exp_resp});
    endtask : rd_chk

    // Reset values, ignored and refused writes
    task automatic reset_values();
        logic [1:0] resp;
        chk({29'h0, port_intr, irq}, 32'h0);
        rd_chk(8'h00, 32'h0, 2'h0);
        rd_chk(8'h10, 32'h0, 2'h0);
        rd_chk(8'h04, 32'h0, 2'h0);
        rd_chk(8'h14, 32'h0, 2'h0);
        rd_chk(8'h20, 32'h0, 2'h0);
        rd_chk(8'h30, 32'h0, 2'h2);
        wr(8'h30, 8'h5a, resp);
        chk({30'h0, resp}, 32'h2);
        wr(8'h00, 8'hff, resp);
        rd_chk(8'h00, 32'h0, 2'h0);
        wr(8'h24, 8'hff, resp);
        rd_chk(8'h24, 32'h3, 2'h0);
        // Write with byte lane 0 off leaves the enable untouched
        s_axi_wstrb <= 4'he;
        wr(8'h04, 8'hff, resp);
        s_axi_wstrb <= 4'hf;
        chk({30'h0, resp}, 32'h0);
        rd_chk(8'h04, 32'h0, 2'h0);
        // Sticky status is read only
        wr(8'h20, 8'h03, resp);
        chk({30'h0, resp}, 32'h0);
        rd_chk(8'h20, 32'h0, 2'h0);
    endtask : reset_values

    // Every line of both ports: fall, rise, then cleared flags
    task automatic pin_levels();
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 4; k++)
            begin
                want_n <= want_n & ~(8'h01 << (2 * k + p));
                repeat (20) @(posedge ref_clk);
                rd_chk(p ? 8'h10 : 8'h00, 32'h10 << k, 2'h0);
                want_n <= want_n | (8'h01 << (2 * k + p));
                repeat (20) @(posedge ref_clk);
                rd_chk(p ? 8'h10 : 8'h00, 32'h1 << k, 2'h0);
                rd_chk(p ? 8'h10 : 8'h00, 32'h0, 2'h0);
            end
    endtask : pin_levels

    // Enabled and masked change events with a slow modem, then port 0 disabled and port 1 enabled with no lag
    task automatic intr_flow();
        logic [1:0] resp;
        wr(8'h04, 8'h08, resp);
        wr(8'h14, 8'h08, resp);
        lag <= 4'h9;
        want_n <= 8'hbf;
        repeat (30) @(posedge ref_clk);
        #1;
        chk({29'h0, port_intr, irq}, 32'h3);
        rd_chk(8'h20, 32'h1, 2'h0);
        #1;
        chk({29'h0, port_intr, irq}, 32'h2);
        rd_chk(8'h00, 32'h80, 2'h0);
        #1;
        chk({30'h0, port_intr}, 32'h0);
        wr(8'h24, 8'h01, resp);
        want_n <= 8'hbd;
        repeat (30) @(posedge ref_clk);
        #1;
        chk({29'h0, port_intr, irq}, 32'h4);
        rd_chk(8'h20, 32'h2, 2'h0);
        rd_chk(8'h10, 32'h10, 2'h0);
        wr(8'h04, 8'h00, resp);
        lag <= 4'h0;
        want_n <= 8'hff;
        repeat (30) @(posedge ref_clk);
        #1;
        chk({30'h0, port_intr}, 32'h2);
        rd_chk(8'h00, 32'h08, 2'h0);
        rd_chk(8'h10, 32'h01, 2'h0);
    endtask : intr_flow

    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        reset_values();
        pin_levels();
        intr_flow();
        conclude();
    end
endmodule : modem_status_top_tb
